/* rtl/pte_pkg.sv */
package pte_pkg;

    // Core clock period; every interval below is converted against it.
    localparam int PTE_CLK_NS = 25;
    // Length of one bit time at 10 Mb/s and at 100 Mb/s.
    localparam int PTE_BIT10_NS = 100;
    localparam int PTE_BIT100_NS = 10;

    // Widths of the short and long timers and the data word, and the FIFO depth.
    localparam int PTE_SHORT_W = 8;
    localparam int PTE_CNT_W = 25;
    localparam int PTE_DIBIT_W = 2;
    localparam int PTE_FIFO_DEPTH = 16;

    // Cycles per microsecond and per millisecond at the core rate.
    localparam int PTE_CYC_PER_US = 1000 / PTE_CLK_NS;
    localparam int PTE_CYC_PER_MS = 1000 * PTE_CYC_PER_US;

    // Least or typical time in ns to cycles, rounded up, never below one.
    function automatic logic [PTE_SHORT_W-1:0] pte_ceil(input int ns);
        int c;
        c = (ns + PTE_CLK_NS - 1) / PTE_CLK_NS;
        return PTE_SHORT_W'((c < 1) ? 1 : c);
    endfunction : pte_ceil

    // Longest time in ns to cycles, rounded down, never below one.
    function automatic logic [PTE_SHORT_W-1:0] pte_floor(input int ns);
        int c;
        c = ns / PTE_CLK_NS;
        return PTE_SHORT_W'((c < 1) ? 1 : c);
    endfunction : pte_floor

    // Short intervals as printed, in ns, bits or tenths of a bit.
    localparam int PTE_CRS_ON10_NS = 630;
    localparam int PTE_CRS_OFF10_NS = 1000;
    localparam int PTE_DV10_BITS = 10;
    localparam int PTE_DATA10_BITS = 8;
    localparam int PTE_HB_DELAY_NS = 1200;
    localparam int PTE_HB_WIDTH_NS = 1000;
    localparam int PTE_NLP_WIDTH_NS = 100;
    localparam int PTE_LB_DV_NS = 240;
    localparam int PTE_TX_RMII_BITS = 17;
    localparam int PTE_CRS_ON100_TBITS = 185;
    localparam int PTE_CRS_OFF100_BITS = 27;
    localparam int PTE_RX_LAT100_BITS = 38;

    // Short intervals in core cycles.
    localparam logic [7:0] PTE_CRS_ON10_CYC = pte_ceil(PTE_CRS_ON10_NS);
    localparam logic [7:0] PTE_CRS_OFF10_CYC = pte_floor(PTE_CRS_OFF10_NS);
    localparam logic [7:0] PTE_DV10_CYC = pte_ceil(PTE_DV10_BITS * PTE_BIT10_NS);
    localparam logic [7:0] PTE_DATA10_CYC = pte_ceil(PTE_DATA10_BITS * PTE_BIT10_NS);
    localparam logic [7:0] PTE_HB_DELAY_CYC = pte_ceil(PTE_HB_DELAY_NS);
    localparam logic [7:0] PTE_HB_WIDTH_CYC = pte_ceil(PTE_HB_WIDTH_NS);
    localparam logic [7:0] PTE_NLP_WIDTH_CYC = pte_ceil(PTE_NLP_WIDTH_NS);
    localparam logic [7:0] PTE_LB_DV_CYC = pte_ceil(PTE_LB_DV_NS);
    localparam int PTE_TX_LAT_CYC = int'(pte_ceil(PTE_TX_RMII_BITS * PTE_BIT100_NS));
    localparam logic [7:0] PTE_CRS_ON100_CYC =
        pte_ceil(PTE_CRS_ON100_TBITS * PTE_BIT100_NS / 10);
    localparam logic [7:0] PTE_CRS_OFF100_CYC =
        pte_ceil(PTE_CRS_OFF100_BITS * PTE_BIT100_NS);
    localparam logic [7:0] PTE_RX_LAT100_CYC = pte_ceil(PTE_RX_LAT100_BITS * PTE_BIT100_NS);

    // Long intervals as printed; their cycle counts are top parameters.
    localparam int PTE_JAB_ON_MS = 85;
    localparam int PTE_JAB_OFF_MS = 500;
    localparam int PTE_NLP_PERIOD_MS = 16;
    localparam int PTE_FLP_PERIOD_MS = 16;
    localparam int PTE_SD_ON_MS = 1;
    localparam int PTE_SD_OFF_US = 350;
    localparam int PTE_LB_DEAD_US = 550;

    // Operating mode straps seen by the timing engine.
    typedef struct packed {
        logic speed_100;
        logic rmii;
        logic half_duplex;
        logic loopback;
        logic autoneg;
    } pte_mode_t;

    // One receive word: error flag and a data dibit.
    typedef struct packed {
        logic err;
        logic [PTE_DIBIT_W-1:0] data;
    } pte_rxw_t;

    // Receive carrier sequence.
    typedef enum logic [2:0] {
        PTE_RX_IDLE,
        PTE_RX_ON,
        PTE_RX_ACT,
        PTE_RX_OFF,
        PTE_RX_TAIL
    } pte_rx_state_t;

endpackage : pte_pkg

/* rtl/pte_fifo.sv */
`timescale 1ns/1ps
module pte_fifo
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers; the extra pointer bit tells full from empty.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    // Full when the pointers differ only in their wrap bit.
    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Entries are written at the write index and never cleared.
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers advance on accepted pushes and pops.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

endmodule : pte_fifo

/* rtl/pte_phy_timing.sv */
`timescale 1ns/1ps
module pte_phy_timing
    import pte_pkg::*;
#(
    parameter int DEPTH = PTE_FIFO_DEPTH,
    parameter int JAB_ON_CYC = PTE_JAB_ON_MS * PTE_CYC_PER_MS,
    parameter int JAB_OFF_CYC = PTE_JAB_OFF_MS * PTE_CYC_PER_MS,
    parameter int NLP_PERIOD_CYC = PTE_NLP_PERIOD_MS * PTE_CYC_PER_MS,
    parameter int FLP_PERIOD_CYC = PTE_FLP_PERIOD_MS * PTE_CYC_PER_MS,
    parameter int SD_ON_CYC = PTE_SD_ON_MS * PTE_CYC_PER_MS,
    parameter int SD_OFF_CYC = PTE_SD_OFF_US * PTE_CYC_PER_US,
    parameter int LB_DEAD_CYC = PTE_LB_DEAD_US * PTE_CYC_PER_US
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pte_mode_t mode,
    input wire logic line_rx_active,
    input wire logic line_rx_sfd,
    input wire logic line_rx_end,
    input wire logic line_rx_valid,
    input wire pte_rxw_t line_rx_word,
    input wire logic line_sig_present,
    input wire logic mac_tx_en,
    input wire logic [PTE_DIBIT_W-1:0] mac_tx_data,
    output logic line_rx_ready,
    output logic mac_crs,
    output logic mac_crs_dv,
    output logic mac_rx_dv,
    output pte_rxw_t mac_rx_word,
    output logic line_tx_en,
    output logic [PTE_DIBIT_W-1:0] line_tx_data,
    output logic collision_heartbeat,
    output logic jabber,
    output logic link_pulse,
    output logic flp_burst,
    output logic signal_detect_internal,
    output logic loopback_dead
);
    localparam int SW = PTE_SHORT_W;
    localparam int CW = PTE_CNT_W;

    // Mode decodes used throughout.
    logic ten;
    logic lb100;
    assign ten = !mode.speed_100;
    assign lb100 = mode.speed_100 && mode.loopback;

    // Sampled transmit inputs and their previous enable.
    logic tx_en_q;
    logic tx_en_d;
    logic [PTE_DIBIT_W-1:0] tx_data_q;

    // Receive source after the loopback selection.
    logic src_active;
    logic src_valid;
    pte_rxw_t src_word;
    logic act_q;
    logic start_ev;
    logic end_ev;
    logic data_ev;

    // Receive sequence state, frame age and off timer.
    pte_rx_state_t state;
    pte_rx_state_t next_state;
    logic [SW-1:0] age;
    logic [SW-1:0] off_cnt;
    logic [SW-1:0] rel_cnt;
    logic rel_run;
    logic rel_on;

    // Delay choices for the current mode.
    logic [SW-1:0] on_cyc;
    logic [SW-1:0] off_cyc;
    logic [SW-1:0] rel_cyc;

    // FIFO handshake.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    pte_rxw_t fifo_out_word;

    // Long timers and the heartbeat timer.
    logic [CW-1:0] jab_cnt;
    logic [CW-1:0] lp_cnt;
    logic [CW-1:0] sd_cnt;
    logic [CW-1:0] dead_cnt;
    logic [SW-1:0] hb_cnt;
    logic hb_run;
    logic lb_q;

    // Transmit pipeline stages.
    logic [PTE_TX_LAT_CYC-1:0] pipe_en;
    logic [PTE_DIBIT_W-1:0] pipe_data [PTE_TX_LAT_CYC];

    // sample on edge
    // The MAC changes its transmit pins on the rising edge, so they are
    // taken here on our own rising edge and used only from the flops.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tx_en_q <= 1'b0;
            tx_en_d <= 1'b0;
            tx_data_q <= '0;
        end
        else
        begin
            tx_en_q <= mac_tx_en;
            tx_en_d <= tx_en_q;
            tx_data_q <= mac_tx_data;
        end
    end

    // In 100 Mb/s loopback the transmit stream stands in for the line.
    always_comb
    begin
        src_active = lb100 ? tx_en_q : line_rx_active;
        src_valid = lb100 ? tx_en_q : line_rx_valid;
        src_word.err = lb100 ? 1'b0 : line_rx_word.err;
        src_word.data = lb100 ? tx_data_q : line_rx_word.data;
    end

    // Edges of activity; at 100 Mb/s on the line the end is the end symbol.
    assign start_ev = src_active && !act_q && !loopback_dead;
    assign end_ev = (mode.speed_100 && !lb100) ? line_rx_end : (act_q && !src_active);
    // count from delimiter
    // At 10 Mb/s the data latency counts from the frame delimiter.
    assign data_ev = ten ? line_rx_sfd : start_ev;

    // Delays per mode; bit counts are converted with the bit times.
    always_comb
    begin
        if (ten)
        begin
            on_cyc = PTE_CRS_ON10_CYC;
            off_cyc = PTE_CRS_OFF10_CYC;
            rel_cyc = PTE_DATA10_CYC;
        end
        else if (lb100)
        begin
            on_cyc = PTE_LB_DV_CYC;
            off_cyc = PTE_CRS_OFF100_CYC;
            rel_cyc = PTE_LB_DV_CYC;
        end
        else
        begin
            on_cyc = PTE_CRS_ON100_CYC;
            off_cyc = PTE_CRS_OFF100_CYC;
            rel_cyc = PTE_RX_LAT100_CYC;
        end
    end

    // Next state of the carrier sequence.
    always_comb
    begin
        next_state = state;
        case (state)
            PTE_RX_IDLE:
            begin
                if (start_ev)
                begin
                    next_state = PTE_RX_ON;
                end
            end
            PTE_RX_ON:
            begin
                // A frame that ends before carrier rises goes straight to PTE_RX_OFF.
                if (end_ev)
                begin
                    next_state = PTE_RX_OFF;
                end
                else if (age >= on_cyc)
                begin
                    next_state = PTE_RX_ACT;
                end
            end
            PTE_RX_ACT:
            begin
                if (end_ev)
                begin
                    next_state = PTE_RX_OFF;
                end
            end
            PTE_RX_OFF:
            begin
                if (off_cnt >= off_cyc)
                begin
                    next_state = fifo_out_valid ? PTE_RX_TAIL : PTE_RX_IDLE;
                end
            end
            PTE_RX_TAIL:
            begin
                if (!fifo_out_valid)
                begin
                    next_state = PTE_RX_IDLE;
                end
            end
            default:
            begin
                next_state = PTE_RX_IDLE;
            end
        endcase
    end

    // State register, frame age and off timer.
    // hold during dead-time
    // The dead-time forces the sequence idle so no frame reaches the MAC.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || loopback_dead)
        begin
            state <= PTE_RX_IDLE;
            age <= '0;
            off_cnt <= '0;
            act_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            act_q <= src_active;
            // Age saturates so a long frame never wraps into a false edge.
            if (start_ev)
            begin
                age <= SW'(1);
            end
            else if (age != '1)
            begin
                age <= age + SW'(1);
            end
            off_cnt <= (state == PTE_RX_OFF) ? off_cnt + SW'(1) : SW'(1);
        end
    end

    // Release timer: the FIFO is drained once the latency has elapsed.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || loopback_dead)
        begin
            rel_cnt <= '0;
            rel_run <= 1'b0;
            rel_on <= 1'b0;
        end
        else if (data_ev && state != PTE_RX_IDLE || start_ev && !ten)
        begin
            rel_cnt <= SW'(1);
            rel_run <= 1'b1;
            rel_on <= 1'b0;
        end
        else if (rel_run && rel_cnt >= rel_cyc)
        begin
            rel_run <= 1'b0;
            rel_on <= 1'b1;
        end
        else if (rel_run)
        begin
            rel_cnt <= rel_cnt + SW'(1);
        end
        else if (state == PTE_RX_IDLE)
        begin
            rel_on <= 1'b0;
        end
    end

    // Draining stalls until release, so the FIFO genuinely fills.
    assign fifo_pop = rel_on && fifo_out_valid;

    pte_fifo
    #(
        .WIDTH($bits(pte_rxw_t)),
        .DEPTH(DEPTH)
    )
    u_fifo
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(src_valid && !loopback_dead),
        .in_ready(fifo_in_ready),
        .in_data(src_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_word)
    );

    // Receive outputs toward the MAC.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            line_rx_ready <= 1'b0;
            mac_crs <= 1'b0;
            mac_crs_dv <= 1'b0;
            mac_rx_dv <= 1'b0;
            mac_rx_word <= '0;
        end
        else
        begin
            // Ready is registered; a word offered when full is dropped.
            line_rx_ready <= fifo_in_ready;
            mac_crs <= (next_state == PTE_RX_ACT) || (next_state == PTE_RX_OFF);
            // assert on carrier
            // Raised from carrier alone, not gated by any data release.
            // toggle at end
            // While the tail drains, the combined signal toggles each cycle.
            if (!mode.rmii)
            begin
                mac_crs_dv <= 1'b0;
            end
            else if (next_state == PTE_RX_TAIL)
            begin
                mac_crs_dv <= !mac_crs_dv;
            end
            else
            begin
                mac_crs_dv <= (next_state == PTE_RX_ACT) || (next_state == PTE_RX_OFF);
            end
            if (ten)
            begin
                mac_rx_dv <= (state != PTE_RX_IDLE) && (age >= PTE_DV10_CYC);
            end
            else
            begin
                mac_rx_dv <= fifo_pop;
            end
            mac_rx_word <= fifo_pop ? fifo_out_word : '0;
        end
    end

    // transmit line latency
    // One stage per cycle of latency; jabber gates the enable at entry.
    generate
        for (genvar i = 0; i < PTE_TX_LAT_CYC; i++)
        begin : g_tx
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    pipe_en[i] <= 1'b0;
                    pipe_data[i] <= '0;
                end
                else if (i == 0)
                begin
                    pipe_en[i] <= tx_en_q && !jabber;
                    pipe_data[i] <= tx_data_q;
                end
                else
                begin
                    pipe_en[i] <= pipe_en[i-1];
                    pipe_data[i] <= pipe_data[i-1];
                end
            end
        end
    endgenerate

    // Line transmit outputs are the last stage, registered once more.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            line_tx_en <= 1'b0;
            line_tx_data <= '0;
        end
        else
        begin
            line_tx_en <= pipe_en[PTE_TX_LAT_CYC-1];
            line_tx_data <= pipe_data[PTE_TX_LAT_CYC-1];
        end
    end

    // heartbeat after transmit
    // Started by the end of transmit at 10 Mb/s half duplex only.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            hb_run <= 1'b0;
            hb_cnt <= '0;
            collision_heartbeat <= 1'b0;
        end
        else
        begin
            if (tx_en_d && !tx_en_q && ten && mode.half_duplex)
            begin
                hb_run <= 1'b1;
                hb_cnt <= SW'(1);
            end
            else if (hb_run && hb_cnt >= PTE_HB_DELAY_CYC + PTE_HB_WIDTH_CYC)
            begin
                hb_run <= 1'b0;
            end
            else if (hb_run)
            begin
                hb_cnt <= hb_cnt + SW'(1);
            end
            collision_heartbeat <= hb_run && (hb_cnt >= PTE_HB_DELAY_CYC)
                && (hb_cnt < PTE_HB_DELAY_CYC + PTE_HB_WIDTH_CYC);
        end
    end

    // clock-derived long timers
    // Release is purely timed; transmit stays cut for the whole hold.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            jabber <= 1'b0;
            jab_cnt <= '0;
        end
        else if (!jabber)
        begin
            if (!(ten && tx_en_q))
            begin
                jab_cnt <= '0;
            end
            else if (jab_cnt >= CW'(JAB_ON_CYC - 1))
            begin
                jabber <= 1'b1;
                jab_cnt <= '0;
            end
            else
            begin
                jab_cnt <= jab_cnt + CW'(1);
            end
        end
        else if (jab_cnt >= CW'(JAB_OFF_CYC - 1))
        begin
            jabber <= 1'b0;
            jab_cnt <= '0;
        end
        else
        begin
            jab_cnt <= jab_cnt + CW'(1);
        end
    end

    // burst spacing
    // One period timer serves both; it holds at zero while transmitting.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            lp_cnt <= '0;
            link_pulse <= 1'b0;
            flp_burst <= 1'b0;
        end
        else if (tx_en_q || !(ten || mode.autoneg))
        begin
            lp_cnt <= '0;
            link_pulse <= 1'b0;
            flp_burst <= 1'b0;
        end
        else
        begin
            if (lp_cnt >= CW'((mode.autoneg ? FLP_PERIOD_CYC : NLP_PERIOD_CYC) - 1))
            begin
                lp_cnt <= '0;
            end
            else
            begin
                lp_cnt <= lp_cnt + CW'(1);
            end
            link_pulse <= !mode.autoneg && (lp_cnt < CW'(PTE_NLP_WIDTH_CYC));
            flp_burst <= mode.autoneg && (lp_cnt == '0);
        end
    end

    // signal detect qualify
    // The input must hold steadily for the whole interval to flip it.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            signal_detect_internal <= 1'b0;
            sd_cnt <= '0;
        end
        else if ((line_sig_present && mode.speed_100) == signal_detect_internal)
        begin
            sd_cnt <= '0;
        end
        else if (sd_cnt >= CW'((signal_detect_internal ? SD_OFF_CYC : SD_ON_CYC) - 1))
        begin
            signal_detect_internal <= !signal_detect_internal;
            sd_cnt <= '0;
        end
        else
        begin
            sd_cnt <= sd_cnt + CW'(1);
        end
    end

    // descrambler dead-time
    // Entering 100 Mb/s loopback starts the dead-time; leaving cancels it.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            lb_q <= 1'b0;
            loopback_dead <= 1'b0;
            dead_cnt <= '0;
        end
        else
        begin
            lb_q <= lb100;
            if (lb100 && !lb_q)
            begin
                loopback_dead <= 1'b1;
                dead_cnt <= '0;
            end
            else if (!lb100 || dead_cnt >= CW'(LB_DEAD_CYC - 1))
            begin
                loopback_dead <= 1'b0;
            end
            else
            begin
                dead_cnt <= dead_cnt + CW'(1);
            end
        end
    end

endmodule : pte_phy_timing

/* verif/pte_phy_timing_assertions.sv */
`timescale 1ns/1ps
module pte_phy_timing_assertions
    import pte_pkg::*;
#(
    parameter int JAB_OFF_CYC = 300
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pte_mode_t mode,
    input wire logic line_rx_active,
    input wire logic mac_tx_en,
    input wire logic mac_crs,
    input wire logic mac_rx_dv,
    input wire logic line_tx_en,
    input wire logic collision_heartbeat,
    input wire logic jabber,
    input wire logic link_pulse,
    input wire logic loopback_dead
);
    // Jabber hold less slack for the output register.
    localparam int JLO = JAB_OFF_CYC - 2;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_tx_rise_lat:
        assert property ($rose(mac_tx_en) && !jabber |-> ##[8:10] $rose(line_tx_en))
        else $error("line enable rise late");
    a_tx_fall_lat:
        assert property ($fell(mac_tx_en) && !jabber |-> ##[8:10] $fell(line_tx_en))
        else $error("line enable fall late");
    a_hb_start:
        assert property ($fell(mac_tx_en) && mode == 5'h04 |-> ##[49:51] $rose(collision_heartbeat))
        else $error("heartbeat start wrong");
    a_hb_width:
        assert property ($rose(collision_heartbeat) |-> ##39 collision_heartbeat ##1 !collision_heartbeat)
        else $error("heartbeat width wrong");
    a_jabber_hold:
        assert property ($rose(jabber) |-> ##JLO jabber ##[1:3] !jabber)
        else $error("jabber hold wrong");
    a_pulse_width:
        assert property ($rose(link_pulse) |-> link_pulse[*4] ##1 !link_pulse)
        else $error("link pulse width wrong");
    a_crs_off_ten:
        assert property ($fell(line_rx_active) && !mode.speed_100 |-> ##[1:42] !mac_crs)
        else $error("carrier held too long");
    a_dead_silent:
        assert property (loopback_dead |-> !mac_rx_dv && !mac_crs)
        else $error("receive active in dead time");
    c_heartbeat: cover property ($rose(collision_heartbeat));
    c_jabber: cover property ($fell(jabber));
    c_dead: cover property ($fell(loopback_dead));
endmodule : pte_phy_timing_assertions
bind pte_phy_timing pte_phy_timing_assertions #(.JAB_OFF_CYC(JAB_OFF_CYC)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .mode(mode), .line_rx_active(line_rx_active),
    .mac_tx_en(mac_tx_en), .mac_crs(mac_crs), .mac_rx_dv(mac_rx_dv), .line_tx_en(line_tx_en),
    .collision_heartbeat(collision_heartbeat), .jabber(jabber), .link_pulse(link_pulse),
    .loopback_dead(loopback_dead));

/* verif/pte_mac_model.sv */
`timescale 1ns/1ps
module pte_mac_model
    import pte_pkg::*;
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic [15:0] frame_len,
    output logic mac_tx_en,
    output logic [PTE_DIBIT_W-1:0] mac_tx_data
);
    // Dibits left to send; zero means idle.
    logic [15:0] left = 16'h0;
    always @(posedge core_clk)
    begin
        if (go)
            left <= frame_len;
        else if (left != 16'h0)
            left <= left - 16'h1;
    end
    assign mac_tx_en = (left != 16'h0);
    assign mac_tx_data = left[1:0];
endmodule : pte_mac_model

/* verif/pte_phy_timing_tb.sv */
`timescale 1ns/1ps
module pte_phy_timing_tb;
    import pte_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic act = 1'b0, sfd = 1'b0, vld = 1'b0, sig = 1'b0, go = 1'b0;
    pte_mode_t mode = 5'h04;
    logic [15:0] flen = 16'h6;
    logic eos = 1'b0;
    pte_rxw_t wrd = 3'h5;
    logic tx_en, rdy, crs, crs_dv, rx_dv, tx_line, hb, jab, lp, flp, sd, dead;
    logic [1:0] tx_d, line_d;
    pte_rxw_t rx_w;
    int num_errors = 0;
    int total_checks = 0;
    pte_mac_model u_pte_mac_model (.core_clk(core_clk), .go(go), .frame_len(flen),
        .mac_tx_en(tx_en), .mac_tx_data(tx_d));
    // Long counts shortened so the run stays short.
    localparam int JON = 200, JOFF = 300, PER = 100, SDON = 50, SDOFF = 30, DEAD = 60;
    pte_phy_timing #(.JAB_ON_CYC(JON), .JAB_OFF_CYC(JOFF), .NLP_PERIOD_CYC(PER),
        .FLP_PERIOD_CYC(PER), .SD_ON_CYC(SDON), .SD_OFF_CYC(SDOFF), .LB_DEAD_CYC(DEAD))
        u_pte_phy_timing (.core_clk(core_clk), .rst_n(rst_n), .mode(mode),
        .line_rx_active(act), .line_rx_sfd(sfd), .line_rx_end(eos), .line_rx_valid(vld),
        .line_rx_word(wrd), .line_sig_present(sig), .mac_tx_en(tx_en), .mac_tx_data(tx_d),
        .line_rx_ready(rdy), .mac_crs(crs), .mac_crs_dv(crs_dv), .mac_rx_dv(rx_dv),
        .mac_rx_word(rx_w), .line_tx_en(tx_line), .line_tx_data(line_d),
        .collision_heartbeat(hb), .jabber(jab), .link_pulse(lp), .flp_burst(flp),
        .signal_detect_internal(sd), .loopback_dead(dead));
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(string what, logic [15:0] lo, logic [15:0] hi, logic [15:0] got);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
            num_errors++;
        end
    endtask : chk
    // Bounded wait; an exhausted bound is a mismatch and ends the run at once.
    task automatic upto(ref logic s, input logic v, inout int n);
        int k;
        for (k = 0; k < 700 && s !== v; k++)
            @(posedge core_clk);
        n = n + k;
        if (s !== v)
        begin
            $display("[ERR] wait expected %0b seen %0b", v, s);
            num_errors++;
            conclude();
        end
    endtask : upto
    task automatic send(input logic [15:0] len);
        flen <= len;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
    endtask : send
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic t_tx;
        int n = 0;
        send(16'h6);
        upto(tx_line, 1'b1, n);
        chk("tx delay", 9, 11, 16'(n));
        chk("tx data", 2, 2, {14'h0, line_d});
        n = 0;
        upto(hb, 1'b1, n);
        chk("heartbeat", 44, 47, 16'(n));
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx;
        int n = 0;
        mode <= 5'h00;
        act <= 1'b1;
        vld <= 1'b1;
        upto(rdy, 1'b0, n);
        chk("fifo full", 16, 19, 16'(n));
        upto(crs, 1'b1, n);
        chk("crs on", 20, 41, 16'(n));
        upto(rx_dv, 1'b1, n);
        chk("rx valid", 38, 45, 16'(n));
        sfd <= 1'b1;
        vld <= 1'b0;
        @(posedge core_clk);
        sfd <= 1'b0;
        repeat (35) @(posedge core_clk);
        chk("rx word", 5, 5, {13'h0, rx_w});
        repeat (35) @(posedge core_clk);
        chk("drained", 1, 1, {15'h0, rdy});
        act <= 1'b0;
        n = 0;
        upto(crs, 1'b0, n);
        chk("crs off", 1, 42, 16'(n));
        $display("t_rx done");
    endtask : t_rx
    task automatic t_jab;
        int n = 0;
        send(16'h190);
        upto(jab, 1'b1, n);
        chk("jabber on", 199, 204, 16'(n));
        n = 0;
        upto(jab, 1'b0, n);
        chk("jabber off", 298, 302, 16'(n));
        n = 0;
        upto(lp, 1'b1, n);
        n = 0;
        upto(lp, 1'b0, n);
        upto(lp, 1'b1, n);
        chk("pulse period", 99, 101, 16'(n));
        upto(lp, 1'b0, n);
        mode <= 5'h01;
        n = 0;
        upto(flp, 1'b1, n);
        n = 0;
        upto(flp, 1'b0, n);
        upto(flp, 1'b1, n);
        chk("burst period", 99, 101, 16'(n));
        $display("t_jab done");
    endtask : t_jab
    task automatic t_hundred;
        int n = 0;
        mode <= 5'h10;
        sig <= 1'b1;
        upto(sd, 1'b1, n);
        chk("detect on", 49, 53, 16'(n));
        sig <= 1'b0;
        n = 0;
        upto(sd, 1'b0, n);
        chk("detect off", 29, 33, 16'(n));
        mode <= 5'h1A;
        n = 0;
        upto(dead, 1'b1, n);
        upto(dead, 1'b0, n);
        chk("dead time", 59, 63, 16'(n));
        n = 0;
        send(16'h20);
        upto(rx_dv, 1'b1, n);
        chk("loop valid", 10, 14, 16'(n));
        chk("crs dv", 1, 1, {15'h0, crs_dv});
        $display("t_hundred done");
    endtask : t_hundred
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_tx();
        t_rx();
        t_jab();
        t_hundred();
        conclude();
    end
endmodule : pte_phy_timing_tb
